// ---- hw/mapper_pkg.sv ----
// Shared constants, mode tables and carrier types of the lane sample mapper.
// Assumes a single 20 MHz frame-rate clock and 12-bit converter samples.
package mapper_pkg;

    // ****************************************************************
    // Widths and timing
    // ****************************************************************
    localparam int CLK_PERIOD_NS = 50;
    localparam int SAMPLE_W = 12;
    localparam int NUM_CH = 4;
    localparam int NUM_LANES = 8;
    localparam int OCTET_W = 8;
    localparam int NIBBLE_W = 4;
    localparam int TEN_W = 10;
    localparam int TAIL_W = 4;
    localparam int LANE_BITS = 64;
    localparam int MAX_SAMPLES = 10;
    localparam int MODE_W = 4;
    localparam int CNT_W = 4;
    localparam int LANES_PER_PAIR = 2;
    localparam int LANES_PER_GROUP = 3;
    localparam int TWO_CH = 2;

    localparam logic [TAIL_W-1:0] TAIL_ZERO = 4'h0;
    localparam logic [MODE_W-1:0] MODE_LAST = 4'h8;
    localparam logic [CNT_W-1:0] LANES_TWO_CH = 4'h4;

    // ****************************************************************
    // Link formats and per-format tables, entry 8 first, entry 0 last
    // ****************************************************************
    typedef enum logic [MODE_W-1:0] {
        FMT_M0 = 4'h0,
        FMT_M1 = 4'h1,
        FMT_M2 = 4'h2,
        FMT_M3 = 4'h3,
        FMT_M4 = 4'h4,
        FMT_M5 = 4'h5,
        FMT_M6 = 4'h6,
        FMT_M7 = 4'h7,
        FMT_M8 = 4'h8
    } link_format_t;

    // Samples per channel per frame.
    localparam logic [8:0][CNT_W-1:0] SAMPLES_TBL =
        {4'h2, 4'h1, 4'h2, 4'h1, 4'h1, 4'h4, 4'h1, 4'h2, 4'hA};
    // Lanes in use.
    localparam logic [8:0][CNT_W-1:0] LANES_TBL =
        {4'h4, 4'h4, 4'h6, 4'h2, 4'h3, 4'h4, 4'h4, 4'h6, 4'h8};
    // Octets per lane frame.
    localparam logic [8:0][CNT_W-1:0] OCTETS_TBL =
        {4'h3, 4'h1, 4'h2, 4'h2, 4'h2, 4'h5, 4'h1, 4'h2, 4'h8};
    // Set where the link uses 64B/66B encoding.
    localparam logic [8:0] ENC64_TBL = 9'h1F0;

    // ****************************************************************
    // Carriers
    // ****************************************************************
    typedef logic [SAMPLE_W-1:0] sample_t;
    typedef sample_t [MAX_SAMPLES-1:0] sample_group_t;
    typedef logic [LANE_BITS-1:0] lane_frame_t;

    typedef struct packed {
        logic valid;
        sample_t [NUM_CH-1:0] sample;
    } sample_set_t;

    typedef struct packed {
        logic valid;
        logic enc_64b66b;
        logic [CNT_W-1:0] octets;
        logic [NUM_LANES-1:0] lane_en;
        lane_frame_t [NUM_LANES-1:0] lane;
    } frame_t;

endpackage

// ---- hw/sample_collector.sv ----
// One channel's sample store: gathers the samples of one frame in time order.
// Assumes samples and controls come from logic on the same clock.
`timescale 1ns/1ps
module sample_collector (
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic restart_in,
    input wire logic valid_in,
    input wire mapper_pkg::sample_t sample_in,
    input wire logic [mapper_pkg::CNT_W-1:0] frame_len_in,
    output mapper_pkg::sample_group_t group_out,
    output logic done_out
);
    import mapper_pkg::*;

    // ****************************************************************
    // Fill state
    // ****************************************************************
    sample_group_t fill_q;
    sample_group_t fill_d;
    sample_group_t group_q;
    logic [CNT_W-1:0] cnt_q;
    logic [CNT_W-1:0] cnt_d;
    logic done_q;
    wire logic len_ok = frame_len_in != '0;
    wire logic last = valid_in && len_ok && (cnt_q == frame_len_in - 1'b1);
    wire logic take = valid_in && !restart_in;

    // Slot n holds sample n, the n-th in time within the frame.
    always_comb begin
        fill_d = fill_q;
        if (cnt_q < CNT_W'(MAX_SAMPLES)) begin
            fill_d[cnt_q] = sample_in;
        end
    end

    // The count wraps straight onto the next frame, so no sample is dropped.
    always_comb begin
        if (restart_in || last) begin
            cnt_d = '0;
        end else if (valid_in) begin
            cnt_d = cnt_q + 1'b1;
        end else begin
            cnt_d = cnt_q;
        end
    end

    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            fill_q <= '0;
            group_q <= '0;
            cnt_q <= '0;
            done_q <= 1'b0;
        end else begin
            cnt_q <= cnt_d;
            done_q <= last && !restart_in;
            if (take) begin
                fill_q <= fill_d;
            end
            if (take && last) begin
                group_q <= fill_d;
            end
        end
    end

    assign group_out = group_q;
    assign done_out = done_q;

endmodule

// ---- hw/converter_lane_sample_mapper.sv ----
// Transport mapper: packs four channels of samples into per-lane frames.
// Assumes one sample set per SAMPLE_IN valid cycle from same-clock logic;
// the format select and channel-count pins are asynchronous straps.
//
// How it works
// - Samples leave MSB first, LSB last.
// - Every tail bit is zero.
// - Sample n is the n-th of its channel.
// - Format 0: five samples per lane, split even/odd.
// - Format 1: six lanes, packed 12-bit pairs.
// - Format 2: one 8-bit sample per lane.
// - Format 3: four 10-bit samples per lane.
// - Format 4: three lanes pack one sample of each channel.
// - Format 5: two lanes of two 8-bit samples.
// - Format 6 packs exactly like format 1.
// - Format 7: one 8-bit sample per lane.
// - Format 8: two 12-bit samples per lane.
// - Use lowest lanes, power down the rest.
`timescale 1ns/1ps
module converter_lane_sample_mapper (
    input wire logic SYS_CLK_IN,
    input wire logic RESET_N_IN,
    input wire logic [mapper_pkg::MODE_W-1:0] LINK_FORMAT_SELECT_IN,
    input wire logic FOUR_CHANNEL_IN,
    input wire mapper_pkg::sample_set_t SAMPLE_IN,
    output mapper_pkg::frame_t FRAME_OUT
);
    import mapper_pkg::*;

    // ****************************************************************
    // Strap synchronisers
    // ****************************************************************
    logic [MODE_W-1:0] fmt_meta_q;
    logic [MODE_W-1:0] fmt_sync_q;
    logic four_meta_q;
    logic four_sync_q;
    logic [MODE_W-1:0] fmt_q;
    logic four_q;

    always_ff @(posedge SYS_CLK_IN) begin
        if (!RESET_N_IN) begin
            fmt_meta_q <= '0;
            fmt_sync_q <= '0;
            four_meta_q <= 1'b0;
            four_sync_q <= 1'b0;
        end else begin
            fmt_meta_q <= LINK_FORMAT_SELECT_IN;
            fmt_sync_q <= fmt_meta_q;
            four_meta_q <= FOUR_CHANNEL_IN;
            four_sync_q <= four_meta_q;
        end
    end

    // A change of format or channel count throws away the partial frame;
    // mixing samples of two layouts in one frame would corrupt both.
    wire logic restart = (fmt_sync_q != fmt_q) || (four_sync_q != four_q);

    always_ff @(posedge SYS_CLK_IN) begin
        if (!RESET_N_IN) begin
            fmt_q <= '0;
            four_q <= 1'b0;
        end else begin
            fmt_q <= fmt_sync_q;
            four_q <= four_sync_q;
        end
    end

    // ****************************************************************
    // Format decode
    // ****************************************************************
    wire logic fmt_ok = fmt_q <= MODE_LAST;
    wire logic [CNT_W-1:0] frame_len =
        fmt_ok ? SAMPLES_TBL[fmt_q] : '0;
    wire logic [CNT_W-1:0] octets =
        fmt_ok ? OCTETS_TBL[fmt_q] : '0;
    wire logic enc64 = fmt_ok && ENC64_TBL[fmt_q];
    wire logic two_ch_m0 = (fmt_q == FMT_M0) && !four_q;
    wire logic [CNT_W-1:0] lanes_used =
        !fmt_ok ? '0 : (two_ch_m0 ? LANES_TWO_CH : LANES_TBL[fmt_q]);
    wire logic take = SAMPLE_IN.valid && fmt_ok;

    logic [NUM_LANES-1:0] lane_en;
    always_comb begin
        for (int l = 0; l < NUM_LANES; l++) begin
            lane_en[l] = l < int'(lanes_used);
        end
    end

    // ****************************************************************
    // Per-channel sample stores
    // ****************************************************************
    sample_group_t grp [NUM_CH];
    logic [NUM_CH-1:0] done;

    genvar ch;
    generate
        for (ch = 0; ch < NUM_CH; ch++) begin : g_ch
            sample_collector u_coll (
                .clk_in(SYS_CLK_IN),
                .rst_n_in(RESET_N_IN),
                .restart_in(restart),
                .valid_in(take),
                .sample_in(SAMPLE_IN.sample[ch]),
                .frame_len_in(frame_len),
                .group_out(grp[ch]),
                .done_out(done[ch])
            );
        end
    endgenerate

    // ****************************************************************
    // Lane packing
    // ****************************************************************
    // Fields are built right-aligned, oldest sample and MSB leftmost, and
    // then shifted so octet 0 sits in the top byte of each lane word.
    lane_frame_t raw [NUM_LANES];
    lane_frame_t packed_lane [NUM_LANES];

    always_comb begin
        int x;
        int y;
        int shift;
        x = 0;
        y = 0;
        shift = LANE_BITS - int'(octets) * OCTET_W;
        for (int l = 0; l < NUM_LANES; l++) begin
            raw[l] = '0;
        end
        case (fmt_q)
            FMT_M0: begin
                for (int c = 0; c < NUM_CH; c++) begin
                    if (c < TWO_CH || four_q) begin
                        x = c * LANES_PER_PAIR;
                        raw[x] = {grp[c][0], grp[c][2], grp[c][4],
                            grp[c][6], grp[c][8], TAIL_ZERO};
                        raw[x + 1] = {grp[c][1], grp[c][3], grp[c][5],
                            grp[c][7], grp[c][9], TAIL_ZERO};
                    end
                end
            end
            FMT_M1, FMT_M6: begin
                for (int g = 0; g < TWO_CH; g++) begin
                    x = g * LANES_PER_PAIR;
                    y = x + 1;
                    raw[g * LANES_PER_GROUP] = lane_frame_t'({grp[x][0],
                        grp[x][1][SAMPLE_W-1 -: NIBBLE_W]});
                    raw[g * LANES_PER_GROUP + 1] = lane_frame_t'({
                        grp[x][1][OCTET_W-1:0],
                        grp[y][0][SAMPLE_W-1 -: OCTET_W]});
                    raw[g * LANES_PER_GROUP + 2] = lane_frame_t'({
                        grp[y][0][NIBBLE_W-1:0], grp[y][1]});
                end
            end
            FMT_M2, FMT_M7: begin
                for (int c = 0; c < NUM_CH; c++) begin
                    raw[c] = lane_frame_t'(
                        grp[c][0][SAMPLE_W-1 -: OCTET_W]);
                end
            end
            FMT_M3: begin
                for (int c = 0; c < NUM_CH; c++) begin
                    raw[c] = lane_frame_t'({
                        grp[c][0][SAMPLE_W-1 -: TEN_W],
                        grp[c][1][SAMPLE_W-1 -: TEN_W],
                        grp[c][2][SAMPLE_W-1 -: TEN_W],
                        grp[c][3][SAMPLE_W-1 -: TEN_W]});
                end
            end
            FMT_M4: begin
                raw[0] = lane_frame_t'({grp[0][0],
                    grp[1][0][SAMPLE_W-1 -: NIBBLE_W]});
                raw[1] = lane_frame_t'({grp[1][0][OCTET_W-1:0],
                    grp[2][0][SAMPLE_W-1 -: OCTET_W]});
                raw[2] = lane_frame_t'({grp[2][0][NIBBLE_W-1:0],
                    grp[3][0]});
            end
            FMT_M5: begin
                raw[0] = lane_frame_t'({
                    grp[0][0][SAMPLE_W-1 -: OCTET_W],
                    grp[1][0][SAMPLE_W-1 -: OCTET_W]});
                raw[1] = lane_frame_t'({
                    grp[2][0][SAMPLE_W-1 -: OCTET_W],
                    grp[3][0][SAMPLE_W-1 -: OCTET_W]});
            end
            FMT_M8: begin
                for (int c = 0; c < NUM_CH; c++) begin
                    raw[c] = lane_frame_t'({grp[c][0],
                        grp[c][1]});
                end
            end
            default: begin
                for (int l = 0; l < NUM_LANES; l++) begin
                    raw[l] = '0;
                end
            end
        endcase
        for (int l = 0; l < NUM_LANES; l++) begin
            if (lane_en[l] && shift < LANE_BITS) begin
                packed_lane[l] = raw[l] << shift;
            end else begin
                packed_lane[l] = '0;
            end
        end
    end

    // ****************************************************************
    // Frame output register
    // ****************************************************************
    // Enabled lane words hold until the next frame, disabled ones clear; lane enables, octet count and
    // encoding follow the applied format continuously.
    frame_t frame_q;
    wire logic frame_done = done[0] && fmt_ok;

    always_ff @(posedge SYS_CLK_IN) begin
        if (!RESET_N_IN) begin
            frame_q <= '0;
        end else begin
            frame_q.valid <= frame_done;
            frame_q.enc_64b66b <= enc64;
            frame_q.octets <= octets;
            frame_q.lane_en <= lane_en;
            for (int l = 0; l < NUM_LANES; l++) begin
                if (frame_done) begin
                    frame_q.lane[l] <= packed_lane[l];
                end else if (!lane_en[l]) begin
                    frame_q.lane[l] <= '0;
                end
            end
        end
    end

    assign FRAME_OUT = frame_q;

endmodule

// ---- tb/mapper_monitor.sv ----
// Concurrent checks on the ports of the lane sample mapper.
// Assumes binding to the mapper top with its single frame clock.
`timescale 1ns/1ps
module mapper_monitor (
    input wire logic SYS_CLK_IN,
    input wire logic RESET_N_IN,
    input wire logic [mapper_pkg::MODE_W-1:0] LINK_FORMAT_SELECT_IN,
    input wire logic FOUR_CHANNEL_IN,
    input wire mapper_pkg::sample_set_t SAMPLE_IN,
    input wire mapper_pkg::frame_t FRAME_OUT
);
    import mapper_pkg::*;
    // ****************************************************************
    // Properties
    // ****************************************************************
    default clocking cb @(posedge SYS_CLK_IN);
    endclocking
    default disable iff (!RESET_N_IN);
    wire frame_t fo = FRAME_OUT;
    wire sample_set_t si = SAMPLE_IN;
    property p_tail;
        fo.valid && fo.octets == 4'h8 |-> fo.lane[0][3:0] == 4'h0;
    endproperty
    a_tail: assert property (p_tail) else $error("tail not zero");
    property p_contig;
        (fo.lane_en & (fo.lane_en + 8'h01)) == 8'h00;
    endproperty
    a_contig: assert property (p_contig) else $error("lane gap");
    property p_off;
        fo.valid && !fo.lane_en[7] |-> fo.lane[7] == '0;
    endproperty
    a_off: assert property (p_off) else $error("idle lane busy");
    property p_wide;
        fo.lane_en[6] |-> fo.octets == 4'h8;
    endproperty
    a_wide: assert property (p_wide) else $error("lane 6 misused");
    property p_enc;
        fo.valid && (fo.octets == 4'h3 || fo.octets == 4'h5)
            |-> fo.enc_64b66b == (fo.octets == 4'h3);
    endproperty
    a_enc: assert property (p_enc) else $error("encoding wrong");
    property p_cause;
        fo.valid |-> $past(si.valid, 2);
    endproperty
    a_cause: assert property (p_cause) else $error("frame uncaused");
    property p_msb;
        fo.valid && fo.octets == 4'h1
            |-> fo.lane[1][63:56] == $past(si.sample[1][11:4], 2)
            && fo.lane[1][55:0] == '0;
    endproperty
    a_msb: assert property (p_msb) else $error("byte lane wrong");
    property p_pair;
        fo.valid && fo.lane_en == 8'h03 |-> fo.lane[1][63:48] ==
            {$past(si.sample[2][11:4], 2), $past(si.sample[3][11:4], 2)};
    endproperty
    a_pair: assert property (p_pair) else $error("pair lane wrong");
    c_f0: cover property (fo.valid && fo.octets == 4'h8);
    c_f8: cover property (fo.valid && fo.octets == 4'h3);
    c_two: cover property (fo.valid && fo.lane_en == 8'h0F);
endmodule
bind converter_lane_sample_mapper mapper_monitor u_mon (
    .SYS_CLK_IN(SYS_CLK_IN),
    .RESET_N_IN(RESET_N_IN),
    .LINK_FORMAT_SELECT_IN(LINK_FORMAT_SELECT_IN),
    .FOUR_CHANNEL_IN(FOUR_CHANNEL_IN),
    .SAMPLE_IN(SAMPLE_IN),
    .FRAME_OUT(FRAME_OUT)
);

// ---- tb/lane_receiver.sv ----
// Far-side receiver model: keeps every frame and rebuilds channel A from format 0 frames.
// Assumes frame words are sampled on the mapper clock.
`timescale 1ns/1ps
module lane_receiver (
    input wire logic clk_in,
    input wire mapper_pkg::frame_t frame_in
);
    import mapper_pkg::*;
    frame_t rx_q[$];
    sample_t ch_a_q[$];
    // ****************************************************************
    // Capture
    // ****************************************************************
    always @(posedge clk_in) begin
        if (frame_in.valid) begin
            rx_q.push_back(frame_in);
            // Lanes 0 and 1 hold even and odd samples, so merge them.
            if (frame_in.octets == 4'h8) begin
                for (int j = 0; j < 10; j++) begin
                    ch_a_q.push_back(
                        frame_in.lane[j % 2][63 - 12 * (j / 2) -: 12]);
                end
            end
        end
    end
endmodule

// ---- tb/converter_lane_sample_mapper_test.sv ----
// Self-checking bench of the lane sample mapper.
// Assumes the receiver model and the bound port checker.
`timescale 1ns/1ps
module converter_lane_sample_mapper_test;
    import mapper_pkg::*;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [MODE_W-1:0] fmt = 4'h0;
    logic four = 1'b1;
    sample_set_t smp = '0;
    frame_t frm;
    int fails = 0;
    int cmp_count = 0;
    int lanes_e[9] = '{8, 6, 4, 4, 3, 2, 6, 4, 4};
    int sets_e[9] = '{10, 2, 1, 4, 1, 1, 2, 1, 2};
    int oct_e[9] = '{8, 2, 1, 5, 2, 2, 2, 1, 3};
    always #25 clk = ~clk;
    converter_lane_sample_mapper dut (
        .SYS_CLK_IN(clk),
        .RESET_N_IN(rst_n),
        .LINK_FORMAT_SELECT_IN(fmt),
        .FOUR_CHANNEL_IN(four),
        .SAMPLE_IN(smp),
        .FRAME_OUT(frm)
    );
    lane_receiver rx (.clk_in(clk), .frame_in(frm));
    // ****************************************************************
    // Helpers
    // ****************************************************************
    function automatic sample_t sv(int k, int c);
        return sample_t'(12'h813 + k * 12'h05B + c * 12'h1C4);
    endfunction
    function automatic lane_frame_t exp_lane(int f, int l, int b);
        lane_frame_t w;
        logic [47:0] p;
        int g;
        w = '0;
        g = 2 * (l / 3);
        p = {sv(b, g), sv(b + 1, g), sv(b, g + 1), sv(b + 1, g + 1)};
        case (f)
            0: begin
                for (int j = 0; j < 5; j++) begin
                    w[63 - 12 * j -: 12] = sv(b + 2 * j + l % 2, l / 2);
                end
            end
            1, 6: w[63:48] = p[47 - 16 * (l % 3) -: 16];
            2, 7: w[63:56] = 8'(sv(b, l) >> 4);
            3: begin
                for (int j = 0; j < 4; j++) begin
                    w[63 - 10 * j -: 10] = 10'(sv(b + j, l) >> 2);
                end
            end
            4: w[63:48] = 16'(64'({sv(b, 0), sv(b, 1), sv(b, 2),
                sv(b, 3)}) >> (32 - 16 * l));
            5: w[63:48] = {8'(sv(b, 2 * l) >> 4), 8'(sv(b, 2 * l + 1) >> 4)};
            default: w[63:40] = {sv(b, l), sv(b + 1, l)};
        endcase
        return w;
    endfunction
    task automatic chk(input logic [63:0] got, input logic [63:0] exp_v);
        cmp_count++;
        if (got !== exp_v) begin
            fails++;
            $display("[FAIL] %0t got %h want %h", $time, got, exp_v);
        end
    endtask
    // Strap changes pass two flops and restart the collectors, so settle.
    task automatic set_fmt(input int f, input logic q);
        @(posedge clk) #1;
        fmt = 4'(f);
        four = q;
        repeat (6) @(posedge clk);
        rx.rx_q.delete();
        rx.ch_a_q.delete();
    endtask
    task automatic send(input int n, input int b);
        for (int k = 0; k < n; k++) begin
            @(posedge clk) #1;
            smp.valid = 1'b1;
            for (int c = 0; c < 4; c++) smp.sample[c] = sv(b + k, c);
        end
        @(posedge clk) #1;
        smp.valid = 1'b0;
    endtask
    task automatic chk_frame(input int f, input int b, input int i,
        input logic q);
        frame_t r;
        lane_frame_t exp_w;
        int n;
        int t;
        t = 0;
        while (rx.rx_q.size() <= i && t < 40) begin
            @(posedge clk);
            t++;
        end
        chk(64'(rx.rx_q.size() > i), 64'h1);
        if (rx.rx_q.size() <= i) return;
        r = rx.rx_q[i];
        n = (f == 0 && !q) ? 4 : lanes_e[f];
        chk(64'(r.lane_en), 64'((1 << n) - 1));
        chk(64'(r.octets), 64'(oct_e[f]));
        chk(64'(r.enc_64b66b), 64'(f >= 4));
        for (int l = 0; l < 8; l++) begin
            exp_w = l < n ? exp_lane(f, l, b) : '0;
            chk(r.lane[l], exp_w);
        end
    endtask
    // ****************************************************************
    // Scenarios
    // ****************************************************************
    task automatic t_all_formats();
        for (int f = 0; f < 9; f++) begin
            set_fmt(f, 1'b1);
            send(sets_e[f], 0);
            chk_frame(f, 0, 0, 1'b1);
        end
    endtask
    task automatic t_back_to_back();
        set_fmt(0, 1'b1);
        send(20, 3);
        chk_frame(0, 3, 0, 1'b1);
        chk_frame(0, 13, 1, 1'b1);
        for (int k = 0; k < 20; k++) begin
            chk(64'(rx.ch_a_q[k]), 64'(sv(3 + k, 0)));
        end
    endtask
    // A reset in mid-run clears the held lane words at the next clock edge.
    task automatic t_reset();
        @(posedge clk) #1;
        rst_n = 1'b0;
        repeat (3) @(posedge clk);
        #1;
        chk(64'(frm.valid), 64'h0);
        chk(64'(frm.lane_en), 64'h0);
        chk(frm.lane[0], 64'h0);
        rst_n = 1'b1;
        repeat (6) @(posedge clk);
        #1;
        chk(64'(frm.lane_en), 64'hFF);
        chk(64'(frm.octets), 64'h8);
    endtask
    // Formats past the last one refuse samples and park every lane.
    task automatic t_idle_format();
        set_fmt(9, 1'b1);
        send(10, 0);
        repeat (4) @(posedge clk);
        #1;
        chk(64'(rx.rx_q.size()), 64'h0);
        chk(64'(frm.lane_en), 64'h0);
        chk(64'(frm.octets), 64'h0);
        chk(frm.lane[0], 64'h0);
    endtask
    task automatic t_two_channel();
        set_fmt(0, 1'b0);
        send(10, 0);
        chk_frame(0, 0, 0, 1'b0);
    endtask
    // A partial frame must not leak into the first frame of a new format.
    task automatic t_abort();
        set_fmt(0, 1'b1);
        send(5, 0);
        set_fmt(3, 1'b1);
        send(4, 9);
        chk_frame(3, 9, 0, 1'b1);
        chk(64'(rx.rx_q.size()), 64'h1);
    endtask
    task automatic conclude();
        $display("Comparisons %0d, mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    initial begin
        repeat (4) @(posedge clk);
        #1 rst_n = 1'b1;
        t_all_formats();
        t_back_to_back();
        t_reset();
        t_two_channel();
        t_abort();
        t_idle_format();
        conclude();
    end
    initial begin
        #200000;
        fails++;
        conclude();
    end
endmodule
